// [hdl/pfi_map.svh]
`ifndef PFI_MAP_SVH
`define PFI_MAP_SVH
`define PFI_ADDR_EN1 8'h05
`define PFI_ADDR_EN2 8'h06
`define PFI_ADDR_STAT1 8'h07
`define PFI_ADDR_STAT2 8'h08
`define PFI_EN1_RESET 8'h7F
`define PFI_EN1_RW_MASK 8'h7C
`define PFI_EN2_RESET 8'hFF
`define PFI_STAT_RESET 8'h00
`define PFI_TEMP_DELTA 8'h03
`define PFI_BIT_TEMP_CHANGE 7
`define PFI_BIT_SHUTDOWN 6
`define PFI_BIT_WARN 5
`define PFI_BIT_HOT 4
`define PFI_BIT_COLD 3
`define PFI_BIT_INPUT_UV 2
`define PFI_BIT_MEASURE 1
`define PFI_BIT_PROGRAM 0
`define PFI_BIT_POS_BOOST 7
`define PFI_BIT_POS_PUMP 6
`define PFI_BIT_INV_CONV 5
`define PFI_BIT_POS_LDO 4
`define PFI_BIT_NEG_PUMP 3
`define PFI_BIT_BIAS_FAULT 2
`define PFI_BIT_NEG_LDO 1
`define PFI_BIT_CONV_DONE 0
`endif

// [hdl/pfi_pkg.sv]
package pfi_pkg;
	typedef logic [7:0] pfi_byte_t;
	typedef logic [9:0] pfi_level_t;
	typedef logic signed [7:0] pfi_temp_t;
endpackage

// [hdl/pfi_fault_irq.sv]
`timescale 1ns/1ps
`include "pfi_map.svh"
module pfi_fault_irq
	import pfi_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic shutdown_in,
	input wire logic warn_in,
	input wire logic input_uv_in,
	input wire logic pos_boost_uv_in,
	input wire logic pos_pump_uv_in,
	input wire logic inv_conv_uv_in,
	input wire logic pos_ldo_uv_in,
	input wire logic neg_pump_uv_in,
	input wire logic bias_fault_in,
	input wire logic neg_ldo_uv_in,
	input wire logic measure_done,
	input wire logic program_done,
	input wire logic temp_valid,
	input wire logic [7:0] temp_value,
	input wire logic [7:0] hot_thresh,
	input wire logic [7:0] cold_thresh,
	output logic irq_out_low
);

	function automatic pfi_byte_t latch_next(pfi_byte_t cur, pfi_byte_t set, logic clr);
		latch_next = (clr ? 8'h00 : cur) | set;
	endfunction

	pfi_level_t pins;
	pfi_level_t sync1_r;
	pfi_level_t sync2_r;
	pfi_level_t sync3_r;
	pfi_level_t lvl_r;
	pfi_byte_t en1_r;
	pfi_byte_t en2_r;
	pfi_byte_t stat1_r;
	pfi_byte_t stat2_r;
	pfi_byte_t set1;
	pfi_byte_t set2;
	pfi_temp_t prev_temp_r;
	pfi_temp_t diff;
	logic [7:0] abs_diff;
	logic hot_cond_r;
	logic cold_cond_r;
	logic temp_change;
	logic clr1;
	logic clr2;
	logic pending;

	assign pins = {shutdown_in, warn_in, input_uv_in, pos_boost_uv_in, pos_pump_uv_in,
		inv_conv_uv_in, pos_ldo_uv_in, neg_pump_uv_in, bias_fault_in, neg_ldo_uv_in};

	// Detector levels are asynchronous; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_r <= 10'h000;
			sync2_r <= 10'h000;
			sync3_r <= 10'h000;
		end else begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Accept a bit only once two stages agree, filtering single-cycle glitches
	always_ff @(posedge clk) begin
		if (srst) begin
			lvl_r <= 10'h000;
		end else begin
			lvl_r <= (lvl_r & ~(sync2_r ^ sync3_r)) | (sync3_r & ~(sync2_r ^ sync3_r));
		end
	end

	assign diff = pfi_temp_t'(temp_value) - prev_temp_r;
	assign abs_diff = diff[7] ? 8'(-diff) : 8'(diff);
	assign temp_change = temp_valid && (abs_diff >= `PFI_TEMP_DELTA);

	// Hot and cold are judged per conversion and held until the next one
	always_ff @(posedge clk) begin
		if (srst) begin
			prev_temp_r <= 8'h00;
			hot_cond_r <= 1'b0;
			cold_cond_r <= 1'b0;
		end else if (temp_valid) begin
			prev_temp_r <= pfi_temp_t'(temp_value);
			hot_cond_r <= pfi_temp_t'(temp_value) >= pfi_temp_t'(hot_thresh);
			cold_cond_r <= pfi_temp_t'(temp_value) <= pfi_temp_t'(cold_thresh);
		end
	end

	always_comb begin
		set1 = 8'h00;
		set1[`PFI_BIT_TEMP_CHANGE] = temp_change;
		set1[`PFI_BIT_SHUTDOWN] = lvl_r[9];
		set1[`PFI_BIT_WARN] = lvl_r[8];
		set1[`PFI_BIT_HOT] = hot_cond_r;
		set1[`PFI_BIT_COLD] = cold_cond_r;
		set1[`PFI_BIT_INPUT_UV] = lvl_r[7];
		set1[`PFI_BIT_MEASURE] = measure_done;
		set1[`PFI_BIT_PROGRAM] = program_done;
		set2 = 8'h00;
		set2[`PFI_BIT_POS_BOOST] = lvl_r[6];
		set2[`PFI_BIT_POS_PUMP] = lvl_r[5];
		set2[`PFI_BIT_INV_CONV] = lvl_r[4];
		set2[`PFI_BIT_POS_LDO] = lvl_r[3];
		set2[`PFI_BIT_NEG_PUMP] = lvl_r[2];
		set2[`PFI_BIT_BIAS_FAULT] = lvl_r[1];
		set2[`PFI_BIT_NEG_LDO] = lvl_r[0];
		set2[`PFI_BIT_CONV_DONE] = temp_valid;
	end

	// Host reading a status register clears it; new events win over the clear
	assign clr1 = reg_rd && (reg_addr == `PFI_ADDR_STAT1);
	assign clr2 = reg_rd && (reg_addr == `PFI_ADDR_STAT2);

	always_ff @(posedge clk) begin
		if (srst) begin
			stat1_r <= `PFI_STAT_RESET;
			stat2_r <= `PFI_STAT_RESET;
		end else begin
			stat1_r <= latch_next(stat1_r, set1, clr1);
			stat2_r <= latch_next(stat2_r, set2, clr2);
		end
	end

	// Read-only enable bits stay at their reset value whatever is written
	always_ff @(posedge clk) begin
		if (srst) begin
			en1_r <= `PFI_EN1_RESET;
			en2_r <= `PFI_EN2_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `PFI_ADDR_EN1) begin
				en1_r <= (en1_r & ~`PFI_EN1_RW_MASK) | (reg_wdata & `PFI_EN1_RW_MASK);
			end
			if (reg_addr == `PFI_ADDR_EN2) begin
				en2_r <= reg_wdata;
			end
		end
	end

	// Read data shows the value before any clear of the same read
	always_ff @(posedge clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`PFI_ADDR_EN1: reg_rdata <= en1_r;
				`PFI_ADDR_EN2: reg_rdata <= en2_r;
				`PFI_ADDR_STAT1: reg_rdata <= stat1_r;
				`PFI_ADDR_STAT2: reg_rdata <= stat2_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	assign pending = (|(stat1_r & en1_r)) || (|(stat2_r & en2_r));

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_out_low <= 1'b1;
		end else begin
			irq_out_low <= ~pending;
		end
	end

	sequence s_shutdown_held;
		shutdown_in [*4];
	endsequence

	sequence s_shutdown_gone;
		!shutdown_in [*4];
	endsequence

	a_irq_asserts: assert property (@(posedge clk) disable iff (srst)
		pending |=> !irq_out_low) else $error("irq not driven low");
	a_irq_releases: assert property (@(posedge clk) disable iff (srst)
		!pending |=> irq_out_low) else $error("irq not released");
	a_en2_reset: assert property (@(posedge clk)
		$past(srst) && srst |-> ##1 en2_r == `PFI_EN2_RESET || reg_wr) else $error("en2 reset");
	a_en1_fixed: assert property (@(posedge clk) disable iff (srst)
		en1_r[7] == 1'b0 && en1_r[1:0] == 2'b11) else $error("en1 fixed bits changed");
	a_temp_change: assert property (@(posedge clk) disable iff (srst)
		temp_valid && abs_diff >= `PFI_TEMP_DELTA |=> stat1_r[7]) else $error("change flag");
	a_no_change: assert property (@(posedge clk) disable iff (srst)
		temp_valid && abs_diff < `PFI_TEMP_DELTA && !stat1_r[7] |=> !stat1_r[7])
		else $error("spurious change flag");
	a_shutdown_flag: assert property (@(posedge clk) disable iff (srst)
		s_shutdown_held |=> lvl_r[9] ##1 stat1_r[6]) else $error("shutdown flag");
	a_shutdown_off: assert property (@(posedge clk) disable iff (srst)
		s_shutdown_gone ##1 clr1 |=> !stat1_r[6]) else $error("shutdown flag stuck");
	a_hot_flag: assert property (@(posedge clk) disable iff (srst)
		temp_valid && $signed(temp_value) >= $signed(hot_thresh) |=> ##1 stat1_r[4])
		else $error("hot flag");
	a_cold_flag: assert property (@(posedge clk) disable iff (srst)
		temp_valid && $signed(temp_value) <= $signed(cold_thresh) |=> ##1 stat1_r[3])
		else $error("cold flag");
	a_measure_flag: assert property (@(posedge clk) disable iff (srst)
		measure_done |=> stat1_r[`PFI_BIT_MEASURE]) else $error("measure done flag");
	a_program_flag: assert property (@(posedge clk) disable iff (srst)
		program_done |=> stat1_r[`PFI_BIT_PROGRAM]) else $error("program done flag");
	a_conv_flag: assert property (@(posedge clk) disable iff (srst)
		temp_valid |=> stat2_r[0]) else $error("conversion flag");
	a_read_clear: assert property (@(posedge clk) disable iff (srst)
		clr2 && set2 == 8'h00 |=> stat2_r == 8'h00) else $error("read did not clear");
	a_stat_ro: assert property (@(posedge clk) disable iff (srst)
		reg_wr && !reg_rd && set1 == 8'h00 && set2 == 8'h00 |=> $stable(stat1_r) && $stable(stat2_r))
		else $error("status changed by write");

	// Read data must carry the status as it stood before the clearing read
	sequence s_stat1_read;
		reg_rd && reg_addr == `PFI_ADDR_STAT1;
	endsequence

	sequence s_stat2_read;
		reg_rd && reg_addr == `PFI_ADDR_STAT2;
	endsequence

	a_rdata_stat1: assert property (@(posedge clk) disable iff (srst)
		s_stat1_read |=> reg_rdata == $past(stat1_r))
		else $error("stat1 read data");
	a_rdata_stat2: assert property (@(posedge clk) disable iff (srst)
		s_stat2_read |=> reg_rdata == $past(stat2_r))
		else $error("stat2 read data");

	// Register file behaviour, reset values and held threshold conditions
	a_stat_reset: assert property (@(posedge clk)
		srst |=> stat1_r == `PFI_STAT_RESET && stat2_r == `PFI_STAT_RESET)
		else $error("status reset value");
	a_out_reset: assert property (@(posedge clk)
		srst |=> irq_out_low && reg_rdata == 8'h00)
		else $error("outputs not idle after reset");
	a_en2_write: assert property (@(posedge clk) disable iff (srst)
		reg_wr && reg_addr == `PFI_ADDR_EN2 |=> en2_r == $past(reg_wdata))
		else $error("en2 write lost");
	a_en1_write: assert property (@(posedge clk) disable iff (srst)
		reg_wr && reg_addr == `PFI_ADDR_EN1 |=> en1_r[6:2] == $past(reg_wdata[6:2]))
		else $error("en1 write lost");
	a_rdata_en1: assert property (@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == `PFI_ADDR_EN1 |=> reg_rdata == $past(en1_r))
		else $error("en1 read data");
	a_thresh_hold: assert property (@(posedge clk) disable iff (srst)
		!temp_valid |=> $stable(hot_cond_r) && $stable(cold_cond_r))
		else $error("threshold condition moved between conversions");

	// Each accepted detector level except shutdown must reach its status bit on the next edge
	a_warn_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[8] |=> stat1_r[`PFI_BIT_WARN])
		else $error("warning flag");
	a_input_uv_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[7] |=> stat1_r[`PFI_BIT_INPUT_UV])
		else $error("input undervoltage flag");
	a_boost_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[6] |=> stat2_r[`PFI_BIT_POS_BOOST])
		else $error("boost flag");
	a_pos_pump_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[5] |=> stat2_r[`PFI_BIT_POS_PUMP])
		else $error("positive pump flag");
	a_inv_conv_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[4] |=> stat2_r[`PFI_BIT_INV_CONV])
		else $error("inverting converter flag");
	a_pos_ldo_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[3] |=> stat2_r[`PFI_BIT_POS_LDO])
		else $error("positive ldo flag");
	a_neg_pump_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[2] |=> stat2_r[`PFI_BIT_NEG_PUMP])
		else $error("negative pump flag");
	a_bias_fault_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[1] |=> stat2_r[`PFI_BIT_BIAS_FAULT])
		else $error("bias fault flag");
	a_neg_ldo_flag: assert property (@(posedge clk) disable iff (srst)
		lvl_r[0] |=> stat2_r[`PFI_BIT_NEG_LDO])
		else $error("negative ldo flag");
endmodule

// [dv/pfi_host_model.sv]
`timescale 1ns/1ps
module pfi_host_model
	import pfi_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	task wr(input pfi_byte_t a, input pfi_byte_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands from the edge after the strobe; take it one edge later
	task rd(input pfi_byte_t a, output pfi_byte_t d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	task service(output pfi_byte_t s1, output pfi_byte_t s2);
		rd(8'h07, s1);
		rd(8'h08, s2);
	endtask
endmodule

// [dv/test_pfi_fault_irq.sv]
`timescale 1ns/1ps
module test_pfi_fault_irq
	import pfi_pkg::*;
;
	logic clk, srst, reg_wr, reg_rd, irq_out_low, mdone, pdone, tvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tval, hot, cold;
	logic [9:0] det;
	pfi_byte_t s1, s2, d;
	int bad_count, checked, cyc;
	pfi_fault_irq pfi_fault_irq_inst(.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.shutdown_in(det[9]), .warn_in(det[8]), .input_uv_in(det[7]),
		.pos_boost_uv_in(det[6]), .pos_pump_uv_in(det[5]), .inv_conv_uv_in(det[4]),
		.pos_ldo_uv_in(det[3]), .neg_pump_uv_in(det[2]), .bias_fault_in(det[1]),
		.neg_ldo_uv_in(det[0]), .measure_done(mdone), .program_done(pdone),
		.temp_valid(tvalid), .temp_value(tval), .hot_thresh(hot), .cold_thresh(cold),
		.irq_out_low(irq_out_low));
	pfi_host_model pfi_host_model_inst(.clk(clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input string n, input pfi_byte_t e, input pfi_byte_t s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task give_verdict;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task t_reset;
		pfi_host_model_inst.rd(8'h06, d);
		chk("en2", 8'hFF, d);
		pfi_host_model_inst.service(s1, s2);
		chk("stat1", 8'h00, s1);
		chk("irq", 8'h01, {7'h00, irq_out_low});
	endtask
	task t_regs;
		pfi_host_model_inst.wr(8'h06, 8'h5A);
		pfi_host_model_inst.rd(8'h06, d);
		chk("en2", 8'h5A, d);
		pfi_host_model_inst.wr(8'h08, 8'hFF);
		pfi_host_model_inst.rd(8'h08, d);
		chk("stat2", 8'h00, d);
		pfi_host_model_inst.rd(8'h33, d);
		chk("unmapped", 8'h00, d);
		pfi_host_model_inst.wr(8'h06, 8'hFF);
	endtask
	// Level detectors held long enough to cross the synchroniser
	task t_det(input int i, input pfi_byte_t e1, input pfi_byte_t e2, input logic ei);
		det <= 10'h001 << i;
		repeat (5) @(posedge clk);
		det <= 10'h000;
		repeat (8) @(posedge clk);
		chk("irq", {7'h00, ei}, {7'h00, irq_out_low});
		pfi_host_model_inst.service(s1, s2);
		chk("stat1", e1, s1);
		chk("stat2", e2, s2);
		pfi_host_model_inst.service(s1, s2);
		repeat (2) @(posedge clk);
		chk("cleared", 8'h00, s1 | s2);
		chk("irq", 8'h01, {7'h00, irq_out_low});
	endtask
	task t_temp(input pfi_byte_t v, input pfi_byte_t e1, input pfi_byte_t e2);
		tval <= v;
		tvalid <= 1'b1;
		@(posedge clk);
		tvalid <= 1'b0;
		repeat (4) @(posedge clk);
		pfi_host_model_inst.service(s1, s2);
		chk("stat1", e1, s1);
		chk("stat2", e2, s2);
	endtask
	initial begin
		srst = 1'b1;
		{det, mdone, pdone, tvalid, tval, cold} = '0;
		hot = 8'h7F;
		cold = 8'h80;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_regs();
		for (int i = 0; i < 7; i++)
			t_det(i, 8'h00, 8'h02 << i, 1'b0);
		t_det(7, 8'h04, 8'h00, 1'b0);
		t_det(8, 8'h20, 8'h00, 1'b0);
		t_det(9, 8'h40, 8'h00, 1'b0);
		pfi_host_model_inst.wr(8'h06, 8'h7F);
		t_det(6, 8'h00, 8'h80, 1'b1);
		pfi_host_model_inst.wr(8'h05, 8'h00);
		pfi_host_model_inst.rd(8'h05, d);
		chk("en1", 8'h03, d);
		t_det(7, 8'h04, 8'h00, 1'b1);
		pfi_host_model_inst.wr(8'h05, 8'hFF);
		pfi_host_model_inst.rd(8'h05, d);
		chk("en1", 8'h7F, d);
		pfi_host_model_inst.wr(8'h06, 8'hFF);
		t_temp(8'h03, 8'h80, 8'h01);
		t_temp(8'h05, 8'h00, 8'h01);
		hot <= 8'h05;
		t_temp(8'h05, 8'h10, 8'h01);
		hot <= 8'h7F;
		cold <= 8'h02;
		// Held threshold conditions re-latch after a read until the next conversion
		t_temp(8'h02, 8'h98, 8'h01);
		cold <= 8'h80;
		t_temp(8'h03, 8'h08, 8'h01);
		mdone <= 1'b1;
		@(posedge clk);
		mdone <= 1'b0;
		pdone <= 1'b1;
		@(posedge clk);
		pdone <= 1'b0;
		repeat (3) @(posedge clk);
		pfi_host_model_inst.service(s1, s2);
		chk("stat1", 8'h03, s1);
		give_verdict();
	end
endmodule
